// [hw/rdmsa_params.svh]
/*
  Constants for the start address and slot information responder:
  register offsets, slot entry field positions, reset values and limits.
  Assumes the including file is compiled after rdmsa_pkg.
*/
`ifndef RDMSA_PARAMS_SVH
`define RDMSA_PARAMS_SVH

// Register byte offsets inside the 4 KB window
`define RDMSA_OFF_CTRL      12'h000
`define RDMSA_OFF_START     12'h004
`define RDMSA_OFF_STATUS    12'h008
`define RDMSA_SLOT_BASE     12'h100
`define RDMSA_SLOT_TOP      12'h1fc
`define RDMSA_DESC_BASE     12'h800

// Slot entry word fields
`define RDMSA_SE_USED       31
`define RDMSA_SE_LEN_LSB    24
`define RDMSA_SE_TYPE_LSB   16

// Reset values
`define RDMSA_START_RST     10'h001
`define RDMSA_FOOT_RST      10'h000

// Protocol limits and codes
`define RDMSA_ADDR_MIN      16'h0001
`define RDMSA_ADDR_MAX      16'h0200
`define RDMSA_NO_ADDR       16'hffff
`define RDMSA_PDL_TWO       8'h02
`define RDMSA_ENTRY_LAST    6'h04
`define RDMSA_ENTRY_BYTES   8'h05
`define RDMSA_ENTRIES_MAX   6'h2e
`define RDMSA_SLOTS         7'h40
`define RDMSA_NR_RANGE      16'h0006
`define RDMSA_NR_FORMAT     16'h0001

`endif

// [hw/rdmsa_pkg.sv]
/*
  Types shared by the responder: request commands, reply kinds and the
  sequencer states. Assumes nothing of its surroundings.
*/
package rdmsa_pkg;

  typedef enum logic [1:0] {
    RDMSA_CMD_GET_START,
    RDMSA_CMD_SET_START,
    RDMSA_CMD_GET_SLOT_INFO,
    RDMSA_CMD_GET_SLOT_DESC
  } rdmsa_cmd_t;

  typedef enum logic [1:0] {
    RDMSA_KIND_ACK,
    RDMSA_KIND_ACK_OVERFLOW,
    RDMSA_KIND_NACK
  } rdmsa_kind_t;

  typedef enum logic [1:0] {
    RDMSA_ST_IDLE,
    RDMSA_ST_SCAN,
    RDMSA_ST_HDR,
    RDMSA_ST_DATA
  } rdmsa_state_t;

endpackage : rdmsa_pkg

// [hw/rdmsa_ahb.sv]
/*
  AHB-Lite slave front end: zero wait states, OKAY always.
  Assumes the register owner decodes rd_addr combinationally.
*/
`timescale 1ns/10ps
module rdmsa_ahb (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Register side
  output logic [11:0]      rd_addr,
  input  wire logic [31:0] rd_data,
  output logic             wr_en,
  output logic [11:0]      wr_addr,
  output logic [31:0]      wr_data
);
  typedef struct packed {
    logic        pend;
    logic [11:0] waddr;
    logic [31:0] rdata;
    logic        ready;
  } rdmsa_ahb_t;

  rdmsa_ahb_t q;
  rdmsa_ahb_t next_q;
  logic       take;

  always_comb begin
    take          = hsel && hready && htrans[1] && (hsize == 3'h2);
    rd_addr       = haddr[11:0];
    next_q        = q;
    next_q.ready  = 1'b1;
    next_q.pend   = take && hwrite;
    if (take) begin
      next_q.waddr = {haddr[11:2], 2'b00};
      if (!hwrite) begin
        next_q.rdata = rd_data;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '{pend: 1'b0, waddr: 12'h000, rdata: 32'h0000_0000, ready: 1'b1};
    end else begin
      q <= next_q;
    end
  end

  assign hreadyout = q.ready;
  assign hresp     = 1'b0;
  assign hrdata    = q.rdata;
  assign wr_en     = q.pend;
  assign wr_addr   = q.waddr;
  assign wr_data   = hwdata;
endmodule : rdmsa_ahb

// [hw/rdmsa_beat.sv]
/*
  One-entry output stage for reply beats; holds a beat until taken.
  Assumes the producer holds an offered beat until in_take is high.
*/
`timescale 1ns/10ps
module rdmsa_beat (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  // Producer side
  input  wire logic                 in_valid,
  input  wire logic                 in_first,
  input  wire logic                 in_last,
  input  wire logic [7:0]           in_byte,
  input  wire rdmsa_pkg::rdmsa_kind_t in_kind,
  input  wire logic [7:0]           in_pdl,
  output logic                      in_take,
  // Reply port
  output logic                      rsp_valid,
  output logic                      rsp_first,
  output logic                      rsp_last,
  output logic [7:0]                rsp_byte,
  output rdmsa_pkg::rdmsa_kind_t    rsp_kind,
  output logic [7:0]                rsp_pdl,
  input  wire logic                 rsp_ready
);
  typedef struct packed {
    logic                   valid;
    logic                   first;
    logic                   last;
    logic [7:0]             data;
    rdmsa_pkg::rdmsa_kind_t kind;
    logic [7:0]             pdl;
  } rdmsa_beat_t;

  rdmsa_beat_t q;
  rdmsa_beat_t next_q;

  always_comb begin
    in_take = !q.valid || rsp_ready;
    next_q  = q;
    if (in_take) begin
      next_q.valid = in_valid;
      next_q.first = in_first;
      next_q.last  = in_last;
      next_q.data  = in_byte;
      next_q.kind  = in_kind;
      next_q.pdl   = in_pdl;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '{valid: 1'b0, first: 1'b0, last: 1'b0, data: 8'h00,
             kind: rdmsa_pkg::RDMSA_KIND_ACK, pdl: 8'h00};
    end else begin
      q <= next_q;
    end
  end

  assign rsp_valid = q.valid;
  assign rsp_first = q.first;
  assign rsp_last  = q.last;
  assign rsp_byte  = q.data;
  assign rsp_kind  = q.kind;
  assign rsp_pdl   = q.pdl;
endmodule : rdmsa_beat

// [hw/rdmsa_core.sv]
/*
  Responder for start address get/set, slot information and slot
  description requests. Holds the start address, footprint, a 64-entry
  slot table and 32-character descriptions, all loaded over AHB-Lite.
  Assumes a packet layer that hands in decoded requests and frames the
  reply beats (header beat first, then parameter data bytes).

// Functional notes
// - Footprint zero: start address GET answers 0xFFFF.
// - Non-zero footprint: GET answers a start address within 1 to 512.
// - Start address is read and written as a 16-bit value.
// - Slot info entries: 16-bit offset, slot type, 16-bit label id.
// - Slot info data at most 0xE6 bytes; longer lists continue via overflow.
// - Slot offsets count from the start address, first slot is 0.
// - Unused or skipped footprint slots are left out of slot info.
// - Primary entries carry a slot function id in the label field.
// - Secondary entries carry the offset of their primary slot.
// - A secondary with many primaries should name the first one.
// - Repeated functions should each get an entry with the same code.
// - Label id 0xFFFF means text only via the description request.
// - Unsupported slot or slot without text gets data-out-of-range.
// - Description reply echoes slot number, then up to 32 characters.
// - English text should resemble the standard slot descriptions.
*/
`timescale 1ns/10ps
`include "rdmsa_params.svh"
module rdmsa_core (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // AHB-Lite register bus
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Decoded request
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire rdmsa_pkg::rdmsa_cmd_t req_cmd,
  input  wire logic [7:0]            req_pdl,
  input  wire logic [15:0]           req_data,
  // Reply beats
  output logic                       rsp_valid,
  output logic                       rsp_first,
  output logic                       rsp_last,
  output logic [7:0]                 rsp_byte,
  output rdmsa_pkg::rdmsa_kind_t     rsp_kind,
  output logic [7:0]                 rsp_pdl,
  input  wire logic                  rsp_ready
);
  typedef struct packed {
    rdmsa_pkg::rdmsa_state_t st;
    rdmsa_pkg::rdmsa_cmd_t   cmd;
    rdmsa_pkg::rdmsa_kind_t  kind;
    logic [9:0]              footprint;
    logic [9:0]              start;
    logic [5:0]              ptr;
    logic [6:0]              idx;
    logic [5:0]              cnt;
    logic                    ovf;
    logic [7:0]              pdl;
    logic [7:0]              rem;
    logic [5:0]              pos;
    logic [5:0]              slot;
    logic [15:0]             val;
    logic                    ready;
  } rdmsa_core_t;

  rdmsa_core_t q;
  rdmsa_core_t next_q;

  logic [31:0] slot_tab [64];
  logic [31:0] desc_mem [512];

  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;

  logic        beat_valid;
  logic        beat_first;
  logic        beat_last;
  logic [7:0]  beat_byte;
  logic        beat_take;

  logic [31:0] cur_ent;
  logic        cur_used;
  logic [31:0] req_ent;
  logic [4:0]  char_i;
  logic [31:0] char_w;
  logic        wr_start;
  logic        start_ok;
  logic        req_start_ok;
  logic        take_req;
  logic        beat_go;

  rdmsa_ahb u_ahb (
    .mclk      (mclk),
    .resetn    (resetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  rdmsa_beat u_beat (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (beat_valid),
    .in_first  (beat_first),
    .in_last   (beat_last),
    .in_byte   (beat_byte),
    .in_kind   (q.kind),
    .in_pdl    (q.pdl),
    .in_take   (beat_take),
    .rsp_valid (rsp_valid),
    .rsp_first (rsp_first),
    .rsp_last  (rsp_last),
    .rsp_byte  (rsp_byte),
    .rsp_kind  (rsp_kind),
    .rsp_pdl   (rsp_pdl),
    .rsp_ready (rsp_ready)
  );

  // Slot table and description text, written by software only
  always_ff @(posedge mclk) begin
    if (wr_en && wr_addr >= `RDMSA_SLOT_BASE && wr_addr <= `RDMSA_SLOT_TOP) begin
      slot_tab[wr_addr[7:2]] <= wr_data;
    end
    if (wr_en && wr_addr >= `RDMSA_DESC_BASE) begin
      desc_mem[wr_addr[10:2]] <= wr_data;
    end
  end

  // Register read decode; unmapped words read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rd_addr[11:2] == `RDMSA_OFF_CTRL >> 2) begin
      rd_data = {22'h00_0000, q.footprint};
    end else if (rd_addr[11:2] == `RDMSA_OFF_START >> 2) begin
      rd_data = {22'h00_0000, q.start};
    end else if (rd_addr[11:2] == `RDMSA_OFF_STATUS >> 2) begin
      rd_data = {22'h00_0000, q.ovf, q.st != rdmsa_pkg::RDMSA_ST_IDLE, 2'b00, q.ptr};
    end else if (rd_addr >= `RDMSA_SLOT_BASE && rd_addr <= `RDMSA_SLOT_TOP) begin
      rd_data = slot_tab[rd_addr[7:2]];
    end else if (rd_addr >= `RDMSA_DESC_BASE) begin
      rd_data = desc_mem[rd_addr[10:2]];
    end
  end

  always_comb begin
    cur_ent  = slot_tab[q.idx[5:0]];
    // Slot offset is the table index, so offset 0 sits at the start address
    cur_used = (q.idx < `RDMSA_SLOTS) && cur_ent[`RDMSA_SE_USED]
               && ({3'b000, q.idx} < q.footprint);
    req_ent  = slot_tab[req_data[5:0]];
    char_i   = 5'(q.pos - 6'h02);
    char_w   = desc_mem[{q.slot, char_i[4:2]}];
    wr_start = wr_en && (wr_addr == `RDMSA_OFF_START);
    start_ok = ({16'h0000, wr_data[31:16]} == 32'h0000_0000)
               && (wr_data[15:0] >= `RDMSA_ADDR_MIN)
               && (wr_data[15:0] <= `RDMSA_ADDR_MAX);
    req_start_ok = (req_data >= `RDMSA_ADDR_MIN) && (req_data <= `RDMSA_ADDR_MAX);
    take_req = q.ready && req_valid;
  end

  always_comb begin
    beat_valid = 1'b0;
    beat_first = 1'b0;
    beat_last  = 1'b0;
    beat_byte  = 8'h00;
    case (q.st)
      rdmsa_pkg::RDMSA_ST_HDR: begin
        beat_valid = 1'b1;
        beat_first = 1'b1;
        beat_last  = (q.pdl == 8'h00);
      end
      rdmsa_pkg::RDMSA_ST_DATA: begin
        beat_valid = (q.kind == rdmsa_pkg::RDMSA_KIND_NACK)
                     || (q.cmd != rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO) || cur_used;
        beat_last  = (q.rem == 8'h01);
        if (q.kind != rdmsa_pkg::RDMSA_KIND_NACK
            && q.cmd == rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO) begin
          // Entry bytes: offset, type, label id; label is passed as stored
          case (q.pos)
            6'h00:   beat_byte = 8'h00;
            6'h01:   beat_byte = {2'b00, q.idx[5:0]};
            6'h02:   beat_byte = cur_ent[`RDMSA_SE_TYPE_LSB +: 8];
            6'h03:   beat_byte = cur_ent[15:8];
            default: beat_byte = cur_ent[7:0];
          endcase
        end else if (q.pos == 6'h00) begin
          beat_byte = q.val[15:8];
        end else if (q.pos == 6'h01) begin
          beat_byte = q.val[7:0];
        end else begin
          beat_byte = char_w[{char_i[1:0], 3'b000} +: 8];
        end
      end
      default: begin
        beat_valid = 1'b0;
      end
    endcase
    beat_go = beat_valid && beat_take;
  end

  always_comb begin
    next_q = q;
    if (wr_en && wr_addr == `RDMSA_OFF_CTRL) begin
      next_q.footprint = wr_data[9:0];
      next_q.ptr       = 6'h00;
    end
    if (wr_start && start_ok) begin
      next_q.start = wr_data[9:0];
    end
    case (q.st)
      rdmsa_pkg::RDMSA_ST_IDLE: begin
        if (take_req) begin
          next_q.cmd  = req_cmd;
          next_q.kind = rdmsa_pkg::RDMSA_KIND_ACK;
          next_q.pos  = 6'h00;
          next_q.st   = rdmsa_pkg::RDMSA_ST_HDR;
          case (req_cmd)
            rdmsa_pkg::RDMSA_CMD_GET_START: begin
              next_q.pdl = `RDMSA_PDL_TWO;
              // Stored address is always 1..512, so only footprint 0 differs
              next_q.val = (q.footprint == 10'h000) ? `RDMSA_NO_ADDR
                           : {6'h00, q.start};
            end
            rdmsa_pkg::RDMSA_CMD_SET_START: begin
              next_q.pdl = `RDMSA_PDL_TWO;
              if (req_pdl != `RDMSA_PDL_TWO) begin
                next_q.kind = rdmsa_pkg::RDMSA_KIND_NACK;
                next_q.val  = `RDMSA_NR_FORMAT;
              end else if (req_start_ok) begin
                next_q.start = req_data[9:0];
                next_q.pdl   = 8'h00;
              end else begin
                next_q.kind = rdmsa_pkg::RDMSA_KIND_NACK;
                next_q.val  = `RDMSA_NR_RANGE;
              end
            end
            rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO: begin
              next_q.st  = rdmsa_pkg::RDMSA_ST_SCAN;
              next_q.idx = {1'b0, q.ptr};
              next_q.cnt = 6'h00;
              next_q.ovf = 1'b0;
            end
            default: begin
              next_q.pdl  = `RDMSA_PDL_TWO;
              next_q.val  = req_data;
              next_q.slot = req_data[5:0];
              if (req_pdl != `RDMSA_PDL_TWO) begin
                next_q.kind = rdmsa_pkg::RDMSA_KIND_NACK;
                next_q.val  = `RDMSA_NR_FORMAT;
              end else if (req_data >= {9'h000, `RDMSA_SLOTS}
                           || {6'h00, req_data[9:0]} >= {6'h00, q.footprint}
                           || !req_ent[`RDMSA_SE_USED]
                           || req_ent[`RDMSA_SE_LEN_LSB +: 6] == 6'h00) begin
                next_q.kind = rdmsa_pkg::RDMSA_KIND_NACK;
                next_q.val  = `RDMSA_NR_RANGE;
              end else begin
                next_q.pdl = `RDMSA_PDL_TWO
                             + {2'b00, req_ent[`RDMSA_SE_LEN_LSB +: 6]};
              end
            end
          endcase
        end
      end
      rdmsa_pkg::RDMSA_ST_SCAN: begin
        // Count reportable entries; stop at the data length limit
        if (q.idx == `RDMSA_SLOTS) begin
          next_q.st   = rdmsa_pkg::RDMSA_ST_HDR;
        end else if (cur_used && q.cnt == `RDMSA_ENTRIES_MAX) begin
          next_q.ovf  = 1'b1;
          next_q.kind = rdmsa_pkg::RDMSA_KIND_ACK_OVERFLOW;
          next_q.st   = rdmsa_pkg::RDMSA_ST_HDR;
        end else begin
          next_q.idx = 7'(q.idx + 7'h01);
          if (cur_used) begin
            next_q.cnt = 6'(q.cnt + 6'h01);
          end
        end
        if (next_q.st == rdmsa_pkg::RDMSA_ST_HDR) begin
          next_q.pdl = 8'(8'(q.cnt) * `RDMSA_ENTRY_BYTES);
          next_q.idx = {1'b0, q.ptr};
          // After an overflow, the next slot info request resumes after the last reported entry; otherwise it starts at slot 0
          next_q.ptr = next_q.ovf ? q.idx[5:0] : 6'h00;
        end
      end
      rdmsa_pkg::RDMSA_ST_HDR: begin
        if (beat_go) begin
          next_q.rem = q.pdl;
          next_q.pos = 6'h00;
          next_q.st  = (q.pdl == 8'h00) ? rdmsa_pkg::RDMSA_ST_IDLE
                       : rdmsa_pkg::RDMSA_ST_DATA;
        end
      end
      rdmsa_pkg::RDMSA_ST_DATA: begin
        if (!beat_valid) begin
          next_q.idx = 7'(q.idx + 7'h01);
        end else if (beat_go) begin
          next_q.rem = 8'(q.rem - 8'h01);
          next_q.pos = 6'(q.pos + 6'h01);
          if (q.cmd == rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO
              && q.kind != rdmsa_pkg::RDMSA_KIND_NACK
              && q.pos == `RDMSA_ENTRY_LAST) begin
            next_q.pos = 6'h00;
            next_q.idx = 7'(q.idx + 7'h01);
          end
          if (beat_last) begin
            next_q.st = rdmsa_pkg::RDMSA_ST_IDLE;
          end
        end
      end
      default: begin
        next_q.st = rdmsa_pkg::RDMSA_ST_IDLE;
      end
    endcase
    next_q.ready = (next_q.st == rdmsa_pkg::RDMSA_ST_IDLE);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '{st: rdmsa_pkg::RDMSA_ST_IDLE, cmd: rdmsa_pkg::RDMSA_CMD_GET_START,
             kind: rdmsa_pkg::RDMSA_KIND_ACK, footprint: `RDMSA_FOOT_RST,
             start: `RDMSA_START_RST, ptr: 6'h00, idx: 7'h00,
             cnt: 6'h00, ovf: 1'b0, pdl: 8'h00, rem: 8'h00, pos: 6'h00,
             slot: 6'h00, val: 16'h0000, ready: 1'b1};
    end else begin
      q <= next_q;
    end
  end

  assign req_ready = q.ready;
endmodule : rdmsa_core

// [verif/rdmsa_sva.sv]
/*
  Checker on the rdmsa_core ports: bus response, reply framing and lengths.
  Assumes one clock domain and binding onto every rdmsa_core instance.
*/
`timescale 1ns/10ps
module rdmsa_sva (
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   resetn,
  // Watched ports
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic                   req_valid,
  input wire logic                   req_ready,
  input wire rdmsa_pkg::rdmsa_cmd_t  req_cmd,
  input wire logic                   rsp_valid,
  input wire logic                   rsp_first,
  input wire logic                   rsp_last,
  input wire logic [7:0]             rsp_byte,
  input wire rdmsa_pkg::rdmsa_kind_t rsp_kind,
  input wire logic [7:0]             rsp_pdl,
  input wire logic                   rsp_ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  rdmsa_pkg::rdmsa_cmd_t lcmd;
  logic                  hd;
  logic                  tk;
  assign hd = rsp_valid && rsp_first;
  assign tk = req_valid && req_ready;
  // Command of the reply now being framed
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lcmd <= rdmsa_pkg::RDMSA_CMD_GET_START;
    end else if (tk) begin
      lcmd <= req_cmd;
    end
  end
  property p_okay; hresp == 1'b0 && hreadyout == 1'b1; endproperty
  a_okay: assert property (p_okay) else $error("bus reply not OKAY");
  property p_hdr; tk && req_cmd != rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO |-> ##2 hd; endproperty
  a_hdr: assert property (p_hdr) else $error("header beat late");
  property p_scan; tk && req_cmd == rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO |-> ##[1:67] hd; endproperty
  a_scan: assert property (p_scan) else $error("slot list header late");
  property p_hold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte) && $stable(rsp_last);
  endproperty
  a_hold: assert property (p_hold) else $error("beat dropped while stalled");
  property p_nack; rsp_valid && rsp_kind == rdmsa_pkg::RDMSA_KIND_NACK |-> rsp_pdl == 8'h02;
  endproperty
  a_nack: assert property (p_nack) else $error("refusal length wrong");
  property p_ovf; hd && rsp_kind == rdmsa_pkg::RDMSA_KIND_ACK_OVERFLOW |-> rsp_pdl == 8'he6;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow length wrong");
  property p_info;
    hd && lcmd == rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO |-> rsp_pdl % 5 == 0 && rsp_pdl <= 8'he6;
  endproperty
  a_info: assert property (p_info) else $error("slot list length wrong");
  property p_get;
    hd && lcmd == rdmsa_pkg::RDMSA_CMD_GET_START |-> rsp_pdl == 8'h02 && !rsp_last;
  endproperty
  a_get: assert property (p_get) else $error("address reply length wrong");
  property p_set;
    hd && lcmd == rdmsa_pkg::RDMSA_CMD_SET_START && rsp_kind == rdmsa_pkg::RDMSA_KIND_ACK
      |-> rsp_pdl == 8'h00 && rsp_last;
  endproperty
  a_set: assert property (p_set) else $error("address set reply wrong");
  property p_desc;
    hd && lcmd == rdmsa_pkg::RDMSA_CMD_GET_SLOT_DESC && rsp_kind == rdmsa_pkg::RDMSA_KIND_ACK
      |-> rsp_pdl inside {[8'h02:8'h22]} && rsp_byte == 8'h00;
  endproperty
  a_desc: assert property (p_desc) else $error("description length wrong");
endmodule : rdmsa_sva
bind rdmsa_core rdmsa_sva u_sva (.mclk, .resetn, .hreadyout, .hresp, .req_valid, .req_ready,
  .req_cmd, .rsp_valid, .rsp_first, .rsp_last, .rsp_byte, .rsp_kind, .rsp_pdl, .rsp_ready);

// [verif/rdmsa_ctl_model.sv]
/*
  Controller side reply sink: takes beats, may stall every other cycle.
  Assumes the bench clears q and done before each request.
*/
`timescale 1ns/10ps
module rdmsa_ctl_model (
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   resetn,
  // Reply beats
  input wire logic                   rsp_valid,
  input wire logic                   rsp_first,
  input wire logic                   rsp_last,
  input wire logic [7:0]             rsp_byte,
  input wire rdmsa_pkg::rdmsa_kind_t rsp_kind,
  input wire logic [7:0]             rsp_pdl,
  output logic                       rsp_ready,
  // Pace
  input wire logic                   slow
);
  logic [7:0]             q[$];
  rdmsa_pkg::rdmsa_kind_t kind;
  logic [7:0]             pdl;
  logic                   done;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rsp_ready <= 1'b0;
    end else begin
      rsp_ready <= slow ? ~rsp_ready : 1'b1;
      if (rsp_valid && rsp_ready) begin
        if (rsp_first) begin
          kind <= rsp_kind;
          pdl <= rsp_pdl;
        end else begin
          q.push_back(rsp_byte);
        end
        if (rsp_last) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule : rdmsa_ctl_model

// [verif/tb_top.sv]
/*
  Self-checking bench for rdmsa_core: AHB-Lite loads, requests, replies.
  Assumes rdmsa_pkg, the design files and the partner model are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  logic mclk, resetn, hsel, hwrite, req_valid, slow, hreadyout, hresp;
  logic rsp_valid, rsp_first, rsp_last, rsp_ready, req_ready;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] req_pdl, rsp_byte, rsp_pdl;
  logic [15:0] req_data;
  rdmsa_pkg::rdmsa_cmd_t req_cmd;
  rdmsa_pkg::rdmsa_kind_t rsp_kind;
  int bad_count, tests_run;
  rdmsa_core dut (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .req_valid, .req_ready, .req_cmd,
    .req_pdl, .req_data, .rsp_valid, .rsp_first, .rsp_last, .rsp_byte, .rsp_kind, .rsp_pdl,
    .rsp_ready);
  rdmsa_ctl_model pm (.mclk, .resetn, .rsp_valid, .rsp_first, .rsp_last, .rsp_byte, .rsp_kind,
    .rsp_pdl, .rsp_ready, .slow);
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task req(input rdmsa_pkg::rdmsa_cmd_t c, input logic [7:0] p, input logic [15:0] d);
    pm.q.delete();
    pm.done = 1'b0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_pdl <= p;
    req_data <= d;
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    while (pm.done !== 1'b1) @(posedge mclk);
  endtask : req
  task expr(input rdmsa_pkg::rdmsa_kind_t k, input logic [7:0] p, input logic [119:0] b,
            input int n);
    chk("kind", 32'(pm.kind), 32'(k));
    chk("pdl", 32'(pm.pdl), 32'(p));
    chk("count", pm.q.size(), n);
    for (int i = 0; i < n; i++) chk("byte", 32'(pm.q[i]), 32'(b[8*(n-1-i)+:8]));
  endtask : expr
  task t_start;
    logic [15:0] v[4], cur;
    v = '{16'h01ff, 16'h0000, 16'h0201, 16'h0200};
    cur = 16'h0001;
    ahb(1'b0, 12'h004, 32'h0000_0000);
    chk("start reset", rd, 32'h0000_0001);
    req(rdmsa_pkg::RDMSA_CMD_GET_START, 8'h00, 16'h0000);
    expr(rdmsa_pkg::RDMSA_KIND_ACK, 8'h02, 120'hffff, 2);
    ahb(1'b1, 12'h000, 32'h0000_0005);
    for (int i = 0; i < 4; i++) begin
      req(rdmsa_pkg::RDMSA_CMD_SET_START, 8'h02, v[i]);
      if (v[i] == 16'h0000 || v[i] > 16'h0200) begin
        expr(rdmsa_pkg::RDMSA_KIND_NACK, 8'h02, 120'h0006, 2);
      end else begin
        cur = v[i];
        expr(rdmsa_pkg::RDMSA_KIND_ACK, 8'h00, 120'h0, 0);
      end
      req(rdmsa_pkg::RDMSA_CMD_GET_START, 8'h00, 16'h0000);
      expr(rdmsa_pkg::RDMSA_KIND_ACK, 8'h02, {104'h0, cur}, 2);
    end
  endtask : t_start
  task t_info;
    slow <= 1'b1;
    ahb(1'b1, 12'h000, 32'h0000_0004);
    ahb(1'b1, 12'h100, 32'h8000_0001);
    ahb(1'b1, 12'h104, 32'h8001_0000);
    ahb(1'b1, 12'h108, 32'h0000_0002);
    ahb(1'b1, 12'h10c, 32'h8000_ffff);
    ahb(1'b1, 12'h110, 32'h8000_0003);
    req(rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO, 8'h00, 16'h0000);
    expr(rdmsa_pkg::RDMSA_KIND_ACK, 8'h0f, 120'h00_0000_0001_0001_0100_0000_0300_ffff, 15);
    slow <= 1'b0;
  endtask : t_info
  task t_ovf;
    ahb(1'b1, 12'h000, 32'h0000_0030);
    for (int i = 0; i < 48; i++) ahb(1'b1, 12'h100 + 12'(4 * i), {16'h8000, 16'(i)});
    req(rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO, 8'h00, 16'h0000);
    chk("ovf kind", 32'(pm.kind), 32'(rdmsa_pkg::RDMSA_KIND_ACK_OVERFLOW));
    chk("ovf count", pm.q.size(), 230);
    for (int i = 0; i < 46; i++) chk("offset", 32'(pm.q[5*i+1]), i);
    req(rdmsa_pkg::RDMSA_CMD_GET_SLOT_INFO, 8'h00, 16'h0000);
    expr(rdmsa_pkg::RDMSA_KIND_ACK, 8'h0a, 120'h002e_0000_2e00_2f00_002f, 10);
  endtask : t_ovf
  task t_desc;
    ahb(1'b1, 12'h10c, 32'h8400_0000);
    ahb(1'b1, 12'h860, 32'h4443_4241);
    ahb(1'b1, 12'h108, 32'h8000_0000);
    req(rdmsa_pkg::RDMSA_CMD_GET_SLOT_DESC, 8'h02, 16'h0003);
    expr(rdmsa_pkg::RDMSA_KIND_ACK, 8'h06, 120'h0003_4142_4344, 6);
    req(rdmsa_pkg::RDMSA_CMD_GET_SLOT_DESC, 8'h02, 16'h0002);
    expr(rdmsa_pkg::RDMSA_KIND_NACK, 8'h02, 120'h0006, 2);
    req(rdmsa_pkg::RDMSA_CMD_GET_SLOT_DESC, 8'h02, 16'h0040);
    expr(rdmsa_pkg::RDMSA_KIND_NACK, 8'h02, 120'h0006, 2);
    req(rdmsa_pkg::RDMSA_CMD_GET_SLOT_DESC, 8'h01, 16'h0003);
    expr(rdmsa_pkg::RDMSA_KIND_NACK, 8'h02, 120'h0001, 2);
  endtask : t_desc
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {resetn, hsel, hwrite, req_valid, slow, htrans, haddr, hwdata} = '0;
    {req_pdl, req_data} = '0;
    req_cmd = rdmsa_pkg::RDMSA_CMD_GET_START;
    hsize = 3'b010;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    t_start;
    t_info;
    t_ovf;
    t_desc;
    finish_test;
  end
  initial begin
    #100us;
    bad_count++;
    finish_test;
  end
endmodule : tb_top
